// ==== tb_timer8_shared_prescaler.sv ====
// Self-checking testbench of the 8-bit timer with shared prescaler.
`timescale 1ns/1ps
`default_nettype none
module tb_timer8_shared_prescaler;
    import tmp_pkg::*;
    localparam int IC = INSTR_CYCLE_CLKS;
    logic        clk_in = 1'b0, srst_in = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, go = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwd = 32'h0, prd, rdv, seed = 32'h00001A02;
    logic [3:0]  pstrb = 4'hF, half = 4'h8;
    logic [4:0]  tog = 5'h00;
    logic        pready, perr, rerr, pin, irq, wtick, wclr;
    int          bad_count = 0, n_compared = 0, cyc = 0, n_tick = 0, n_clr = 0, k, b;
    logic [7:0]  v;
    always #2.5 clk_in = ~clk_in;
    tmp_timer8 i_dut (.clk_in(clk_in), .srst_in(srst_in), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwd), .pstrb_in(pstrb), .prdata_out(prd),
        .pready_out(pready), .pslverr_out(perr), .ext_count_input_in(pin),
        .overflow_irq_out(irq), .wdt_tick_out(wtick), .wdt_clear_out(wclr));
    tmp_ext_clk_src i_src (.clk_in(clk_in), .go_in(go), .toggles_in(tog), .half_in(half), .pin_out(pin));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chkr(input string s, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] g);
        n_compared++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            bad_count++;
            $display("Error %s expected %0d to %0d seen %h", s, lo, hi, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_in);
        psel <= 1'b1; pwr <= w; paddr <= a; pwd <= d;
        @(posedge clk_in);
        pen <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n == 40) bad_count++;
        rdv = prd;
        rerr = perr;
        psel <= 1'b0; pen <= 1'b0;
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc++;
        n_tick += wtick;
        n_clr += wclr;
        if (cyc == 20000) begin
            bad_count++;
            stop_test();
        end
    end
    initial begin
        repeat (12) @(posedge clk_in);
        srst_in <= 1'b0;
        apb(0, ADDR_OPTION_CONFIG, 0); chk("option", 32'h000000FF, rdv);
        apb(0, ADDR_INTR_CONTROL, 0); chk("intr", 0, rdv);
        apb(0, 12'hFF0, 0); chk("unmapped", 1, rerr);
        pstrb <= 4'h0;
        apb(1, ADDR_OPTION_CONFIG, 0);
        pstrb <= 4'hF;
        apb(0, ADDR_OPTION_CONFIG, 0); chk("strobe", 32'h000000FF, rdv);
        $display("test reset finished");
        v = rnd();
        v[7] = 1'b0;
        apb(1, ADDR_OPTION_CONFIG, 32'h08);
        apb(1, ADDR_TIMER_COUNT, v);
        repeat (10 * IC) @(posedge clk_in);
        apb(0, ADDR_TIMER_COUNT, 0); chkr("timer", v + 8, v + 9, rdv);
        for (k = 0; k < 3; k++) begin
            apb(1, ADDR_OPTION_CONFIG, k);
            apb(1, ADDR_TIMER_COUNT, 0);
            repeat (6 * IC << (k + 1)) @(posedge clk_in);
            apb(0, ADDR_TIMER_COUNT, 0); chkr("prescaled", 4, 6, rdv);
            apb(0, ADDR_OPTION_CONFIG, 0); chk("option kept", k, rdv);
        end
        $display("test timer finished");
        // Clear the count, and with it the prescaler, before the owner moves to the watchdog.
        apb(1, ADDR_TIMER_COUNT, 0);
        half <= 4'h8 | 4'(rnd());
        k = rnd() % 8 + 3;
        for (b = 0; b < 2; b++) begin
            apb(1, ADDR_OPTION_CONFIG, 32'h28 | (b << 4));
            apb(1, ADDR_TIMER_COUNT, 0);
            repeat (3 * IC) @(posedge clk_in);
            tog <= 5'(2 * k - 1);
            go <= 1'b1;
            @(posedge clk_in);
            go <= 1'b0;
            repeat ((2 * k + 1) * (half + 1)) @(posedge clk_in);
            apb(0, ADDR_TIMER_COUNT, 0); chk("edges", k, rdv);
        end
        $display("test counter finished");
        apb(1, ADDR_OPTION_CONFIG, 32'h08);
        apb(1, ADDR_INTR_CONTROL, 32'h20);
        apb(1, ADDR_TIMER_COUNT, 32'hFE);
        repeat (6 * IC) @(posedge clk_in);
        apb(0, ADDR_INTR_CONTROL, 0); chk("flag", 32'h24, rdv);
        chk("irq", 1, irq);
        apb(1, ADDR_INTR_CONTROL, 32'h04);
        repeat (2) @(posedge clk_in);
        chk("masked", 0, irq);
        apb(0, ADDR_INTR_CONTROL, 0); chk("flag kept", 32'h04, rdv);
        apb(1, ADDR_CONTROL, 32'h1);
        apb(0, ADDR_TIMER_COUNT, 0);
        v = rdv[7:0];
        repeat (4 * IC) @(posedge clk_in);
        apb(0, ADDR_TIMER_COUNT, 0); chk("sleep", v, rdv);
        apb(1, ADDR_CONTROL, 0);
        $display("test overflow finished");
        apb(1, ADDR_OPTION_CONFIG, 32'h09);
        k = n_tick;
        repeat (20 * IC) @(posedge clk_in);
        chkr("wdt ticks", 9, 11, n_tick - k);
        k = n_clr;
        apb(1, ADDR_CONTROL, 32'h2);
        repeat (4) @(posedge clk_in);
        chk("wdt clear", 1, n_clr - k);
        $display("test watchdog finished");
        stop_test();
    end
endmodule // tb_timer8_shared_prescaler
`default_nettype wire

// ==== tmp_edge_sync.sv ====
// Two-flop synchroniser and edge selector for the external count pin.
`timescale 1ns/1ps
`default_nettype none
module tmp_edge_sync (
    input  wire logic clk_in,
    input  wire logic srst_in,
    input  wire logic pin_in,
    input  wire logic falling_in,
    output logic      edge_out
);
    logic meta;
    logic sync;
    logic prev;
    logic next_edge;

    always_comb begin
        next_edge = falling_in ? (prev & ~sync) : (~prev & sync);
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            meta     <= 1'b0;
            sync     <= 1'b0;
            prev     <= 1'b0;
            edge_out <= 1'b0;
        end else begin
            meta     <= pin_in;
            sync     <= meta;
            prev     <= sync;
            edge_out <= next_edge;
        end
    end
endmodule // tmp_edge_sync
`default_nettype wire

// ==== tmp_ext_clk_src.sv ====
// External clock source model that drives the count pin.
`timescale 1ns/1ps
`default_nettype none
module tmp_ext_clk_src (
    input  wire logic       clk_in,
    input  wire logic       go_in,
    input  wire logic [4:0] toggles_in,
    input  wire logic [3:0] half_in,
    output logic            pin_out
);
    int left = 0;
    int cnt  = 0;
    initial pin_out = 1'b0;
    // The pin holds its level between bursts, as a gated clock would.
    always @(posedge clk_in) begin
        if (go_in) begin
            left <= int'(toggles_in);
            cnt  <= 0;
        end else if (left > 0) begin
            if (cnt == int'(half_in) - 1) begin
                pin_out <= ~pin_out;
                left    <= left - 1;
                cnt     <= 0;
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule // tmp_ext_clk_src
`default_nettype wire

// ==== tmp_pkg.sv ====
// Package with register map, field positions and reset values of the 8-bit timer block.
package tmp_pkg;
    localparam int ADDR_W = 12;
    // Printed offsets are not all multiples of four, so they are indices; byte address is four times the index.
    localparam logic [9:0] IDX_TIMER_COUNT   = 10'h001;
    localparam logic [9:0] IDX_INTR_CONTROL  = 10'h00B;
    localparam logic [9:0] IDX_OPTION_CONFIG = 10'h081;
    localparam logic [9:0] IDX_CONTROL       = 10'h0C0;
    localparam logic [ADDR_W-1:0] ADDR_TIMER_COUNT   = {IDX_TIMER_COUNT, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_INTR_CONTROL  = {IDX_INTR_CONTROL, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_OPTION_CONFIG = {IDX_OPTION_CONFIG, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_CONTROL       = {IDX_CONTROL, 2'b00};
    localparam int BIT_CLOCK_SOURCE_SEL    = 5;
    localparam int BIT_SOURCE_EDGE_SEL     = 4;
    localparam int BIT_PRESCALER_ASSIGN    = 3;
    localparam int BIT_OVERFLOW_IRQ_ENABLE = 5;
    localparam int BIT_OVERFLOW_FLAG       = 2;
    localparam int BIT_CTRL_SLEEP          = 0;
    localparam int BIT_CTRL_WDT_CLEAR      = 1;
    localparam logic [7:0] OPTION_RESET    = 8'hFF;
    localparam logic [7:0] INTR_RESET      = 8'h00;
    localparam logic [7:0] COUNT_RESET     = 8'h00;
    localparam logic [7:0] COUNT_MAX       = 8'hFF;
    localparam int WRITE_INHIBIT_CYCLES    = 2;
    // Instruction cycle of 200 ns at a 5 ns clock.
    localparam int CLK_PERIOD_NS           = 5;
    localparam int INSTR_CYCLE_NS          = 200;
    localparam int INSTR_CYCLE_CLKS        = INSTR_CYCLE_NS / CLK_PERIOD_NS;
endpackage : tmp_pkg

// ==== tmp_prescaler.sv ====
// Shared 8-bit prescaler with tap selection for timer or watchdog use.
`timescale 1ns/1ps
`default_nettype none
module tmp_prescaler #(
    parameter int WIDTH = 8
) (
    input  wire logic       clk_in,
    input  wire logic       srst_in,
    input  wire logic       tick_in,
    input  wire logic       clear_in,
    input  wire logic [2:0] ratio_in,
    input  wire logic       to_wdt_in,
    output logic            tick_out
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    logic [WIDTH:0]   mask;
    logic             next_tick;
    logic [3:0]       tap;

    always_comb begin
        mask       = ({{WIDTH{1'b0}}, 1'b1} << tap) - {{WIDTH{1'b0}}, 1'b1};
        next_count = count;
        next_tick  = 1'b0;
        tap        = to_wdt_in ? {1'b0, ratio_in} : ({1'b0, ratio_in} + 4'h1);
        if (clear_in) begin
            next_count = '0;
        end else if (tick_in) begin
            next_count = count + 1'b1;
            // Output fires when all bits below the tap are ones, a divide by 2^tap.
            next_tick  = &(count | ~mask[WIDTH-1:0]);
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            count    <= '0;
            tick_out <= 1'b0;
        end else begin
            count    <= next_count;
            tick_out <= next_tick;
        end
    end
endmodule // tmp_prescaler
`default_nettype wire

// ==== tmp_timer8.sv ====
// Top of the 8-bit timer/counter with shared prescaler and APB register slave.
// Notes on behaviour
// - Timer mode counts every instruction cycle while watchdog owns prescaler
// - Count write blocks counting two cycles
// - Counter mode counts external pin edges
// - Edge select: clear rising, set falling
// - External pin synchronised before counting
// - One prescaler, timer or watchdog only
// - Prescaler count never visible to software
// - Option low bits choose owner, ratio
// - Timer owner: ratios 1:2 to 1:256
// - Watchdog owner: ratios 1:1 to 1:128
// - Count write clears prescaler if timer owns it, keeps option
// - Watchdog clear zeroes prescaler if watchdog owns it
// - Assignment may change at any time
// - Rollover FFh to 00h sets flag
// - Enable bit masks overflow interrupt request
// - Timer stops during sleep, no wakeup
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module tmp_timer8 (
    input  wire logic                       clk_in,
    input  wire logic                       srst_in,
    input  wire logic                       psel_in,
    input  wire logic                       penable_in,
    input  wire logic                       pwrite_in,
    input  wire logic [tmp_pkg::ADDR_W-1:0] paddr_in,
    input  wire logic [31:0]                pwdata_in,
    input  wire logic [3:0]                 pstrb_in,
    output logic      [31:0]                prdata_out,
    output logic                            pready_out,
    output logic                            pslverr_out,
    input  wire logic                       ext_count_input_in,
    output logic                            overflow_irq_out,
    output logic                            wdt_tick_out,
    output logic                            wdt_clear_out
);
    import tmp_pkg::*;

    logic [7:0] timer_count;
    logic [7:0] intr_control;
    logic [7:0] option_config;
    logic       sleep_mode;
    logic [1:0] inhibit;
    logic [5:0] cyc_count;
    logic       instr_tick;
    logic [7:0] next_timer_count;
    logic [7:0] next_intr_control;
    logic [7:0] next_option_config;
    logic       next_sleep_mode;
    logic [1:0] next_inhibit;
    logic [5:0] next_cyc_count;
    logic       next_instr_tick;
    logic [31:0] next_prdata;
    logic       next_pready;
    logic       next_pslverr;
    logic       next_irq;
    logic       next_wdt_tick;
    logic       next_wdt_clear;
    logic       ext_edge;
    logic       pre_tick;
    logic       pre_in;
    logic       pre_clear;
    logic       source_tick;
    logic       count_tick;
    logic       access;
    logic       wr;
    logic       wr_count;
    logic       wdt_owner;
    logic       wdt_clear_req;

    assign access    = psel_in & penable_in & ~pready_out;
    assign wr        = access & pwrite_in & pstrb_in[0];
    assign wr_count  = wr & (paddr_in == ADDR_TIMER_COUNT);
    assign wdt_owner = option_config[BIT_PRESCALER_ASSIGN];
    assign wdt_clear_req = wr & (paddr_in == ADDR_CONTROL) & pwdata_in[BIT_CTRL_WDT_CLEAR];

    tmp_edge_sync u_sync (
        .clk_in     (clk_in),
        .srst_in    (srst_in),
        .pin_in     (ext_count_input_in),
        .falling_in (option_config[BIT_SOURCE_EDGE_SEL]),
        .edge_out   (ext_edge)
    );

    // Source tick: instruction cycle in timer mode, pin edge in counter mode.
    assign source_tick = option_config[BIT_CLOCK_SOURCE_SEL] ? ext_edge : instr_tick;
    // In watchdog use the prescaler is fed by the watchdog base tick, here the instruction cycle.
    assign pre_in      = wdt_owner ? instr_tick : (source_tick & ~sleep_mode);
    assign pre_clear   = wdt_owner ? wdt_clear_req : wr_count;

    tmp_prescaler #(
        .WIDTH (8)
    ) u_pre (
        .clk_in    (clk_in),
        .srst_in   (srst_in),
        .tick_in   (pre_in),
        .clear_in  (pre_clear),
        .ratio_in  (option_config[2:0]),
        .to_wdt_in (wdt_owner),
        .tick_out  (pre_tick)
    );

    assign count_tick = wdt_owner ? (source_tick & ~sleep_mode) : pre_tick;

    always_comb begin
        next_cyc_count  = cyc_count + 6'd1;
        next_instr_tick = 1'b0;
        if (cyc_count == 6'(INSTR_CYCLE_CLKS - 1)) begin
            next_cyc_count  = '0;
            next_instr_tick = 1'b1;
        end
    end

    always_comb begin
        next_timer_count   = timer_count;
        next_intr_control  = intr_control;
        next_option_config = option_config;
        next_sleep_mode    = sleep_mode;
        next_inhibit       = inhibit;
        if (instr_tick && inhibit != 2'd0) begin
            next_inhibit = inhibit - 2'd1;
        end
        if (count_tick && inhibit == 2'd0 && !sleep_mode) begin
            next_timer_count = timer_count + 8'h01;
        end
        if (wr) begin
            case (paddr_in)
                ADDR_TIMER_COUNT: begin
                    next_timer_count = pwdata_in[7:0];
                    next_inhibit     = 2'(WRITE_INHIBIT_CYCLES);
                end
                ADDR_INTR_CONTROL:  next_intr_control  = pwdata_in[7:0];
                ADDR_OPTION_CONFIG: next_option_config = pwdata_in[7:0];
                ADDR_CONTROL:       next_sleep_mode    = pwdata_in[BIT_CTRL_SLEEP];
                default: begin
                end
            endcase
        end
        // Hardware set wins over a software clear in the same cycle.
        if (count_tick && inhibit == 2'd0 && !sleep_mode && timer_count == COUNT_MAX && !wr_count) begin
            next_intr_control[BIT_OVERFLOW_FLAG] = 1'b1;
        end
    end

    always_comb begin
        next_prdata  = '0;
        next_pready  = access;
        next_pslverr = 1'b0;
        if (access && !pwrite_in) begin
            case (paddr_in)
                ADDR_TIMER_COUNT:   next_prdata = {24'h000000, timer_count};
                ADDR_INTR_CONTROL:  next_prdata = {24'h000000, intr_control};
                ADDR_OPTION_CONFIG: next_prdata = {24'h000000, option_config};
                ADDR_CONTROL:       next_prdata = {31'h00000000, sleep_mode};
                default:            next_pslverr = 1'b1;
            endcase
        end else if (access) begin
            case (paddr_in)
                ADDR_TIMER_COUNT, ADDR_INTR_CONTROL, ADDR_OPTION_CONFIG, ADDR_CONTROL: next_pslverr = 1'b0;
                default: next_pslverr = 1'b1;
            endcase
        end
        next_irq = next_intr_control[BIT_OVERFLOW_FLAG] & next_intr_control[BIT_OVERFLOW_IRQ_ENABLE];
        next_wdt_tick  = wdt_owner ? pre_tick : instr_tick;
        next_wdt_clear = wdt_clear_req;
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            timer_count      <= COUNT_RESET;
            intr_control     <= INTR_RESET;
            option_config    <= OPTION_RESET;
            sleep_mode       <= 1'b0;
            inhibit          <= 2'd0;
            cyc_count        <= '0;
            instr_tick       <= 1'b0;
            prdata_out       <= '0;
            pready_out       <= 1'b0;
            pslverr_out      <= 1'b0;
            overflow_irq_out <= 1'b0;
            wdt_tick_out     <= 1'b0;
            wdt_clear_out    <= 1'b0;
        end else begin
            timer_count      <= next_timer_count;
            intr_control     <= next_intr_control;
            option_config    <= next_option_config;
            sleep_mode       <= next_sleep_mode;
            inhibit          <= next_inhibit;
            cyc_count        <= next_cyc_count;
            instr_tick       <= next_instr_tick;
            prdata_out       <= next_prdata;
            pready_out       <= next_pready;
            pslverr_out      <= next_pslverr;
            overflow_irq_out <= next_irq;
            wdt_tick_out     <= next_wdt_tick;
            wdt_clear_out    <= next_wdt_clear;
        end
    end
endmodule // tmp_timer8
`default_nettype wire

// ==== tmp_timer8_asserts.sv ====
// Port timing checker of the 8-bit timer block.
`timescale 1ns/1ps
`default_nettype none
module tmp_timer8_asserts
    import tmp_pkg::*;
(
    input wire logic              clk_in,
    input wire logic              srst_in,
    input wire logic              psel_in,
    input wire logic              penable_in,
    input wire logic              pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0]       pwdata_in,
    input wire logic [3:0]        pstrb_in,
    input wire logic [31:0]       prdata_out,
    input wire logic              pready_out,
    input wire logic              pslverr_out,
    input wire logic              overflow_irq_out,
    input wire logic              wdt_clear_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    wire acc = psel_in & penable_in & ~pready_out;
    wire wr  = acc & pwrite_in & pstrb_in[0];
    wire map = paddr_in == ADDR_TIMER_COUNT || paddr_in == ADDR_INTR_CONTROL
            || paddr_in == ADDR_OPTION_CONFIG || paddr_in == ADDR_CONTROL;
    wire wic = wr & (paddr_in == ADDR_INTR_CONTROL);
    wire wcl = wr & (paddr_in == ADDR_CONTROL) & pwdata_in[BIT_CTRL_WDT_CLEAR];
    AST_RDY_ANSWER: assert property (acc |=> pready_out)
        else $error("access not answered");
    AST_RDY_PULSE: assert property (pready_out |=> !pready_out)
        else $error("ready longer than one cycle");
    AST_ERR_DECODE: assert property (acc |=> pslverr_out == !map)
        else $error("error response wrong");
    AST_RD_UPPER: assert property (pready_out |-> prdata_out[31:8] == 24'h000000)
        else $error("read data upper bits set");
    AST_IRQ_MASK: assert property (wic & !pwdata_in[BIT_OVERFLOW_IRQ_ENABLE] |-> ##2 !overflow_irq_out)
        else $error("masked request still high");
    AST_IRQ_HOLD: assert property ($fell(overflow_irq_out) |->
        $past(wic) || $past(wic, 2) || $past(srst_in) || $past(srst_in, 2))
        else $error("request fell without software");
    AST_WDT_CLR: assert property (wcl |-> ##[1:2] wdt_clear_out)
        else $error("watchdog clear missing");
    AST_WDT_CAUSE: assert property ($rose(wdt_clear_out) |-> $past(wcl) || $past(wcl, 2))
        else $error("watchdog clear without write");
    AST_CLR_PULSE: assert property (wdt_clear_out |=> !wdt_clear_out)
        else $error("watchdog clear too long");
    cover property ($rose(overflow_irq_out));
    cover property (pslverr_out);
    cover property (wdt_clear_out);
endmodule // tmp_timer8_asserts
bind tmp_timer8 tmp_timer8_asserts u_chk (.*);
`default_nettype wire
